// ---- rtl/irq_wake_pkg.sv ----
package irq_wake_pkg;

	// ----------------------------------------
	// Register map and reset values
	// ----------------------------------------
	localparam logic [7:0] opt_offset = 8'hc8;
	localparam logic [7:0] opt_reset = 8'h00;
	localparam logic [7:0] read_zero = 8'h00;

	// Field positions inside the option byte
	localparam int src1_level_pos = 6;
	localparam int src2_polarity_pos = 5;
	localparam int global_en_pos = 4;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	// Oscillator settle wait after a stop wake, in ns; plain default
	localparam int ref_clk_ns = 50;
	localparam int settle_time_ns = 102400;
	localparam logic [12:0] settle_cycles =
		13'((settle_time_ns + ref_clk_ns - 1) / ref_clk_ns);

	// Source numbers; 0 is the non-maskable one
	localparam int num_src = 5;
	localparam int num_pins = 8;

	// Option byte as stored
	typedef struct packed {
		logic unused_7;
		logic src1_level_select;
		logic src2_polarity_select;
		logic global_irq_enable;
		logic [3:0] unused_3_0;
	} opt_type;

	// Peripheral event flags and their enables
	typedef struct packed {
		logic timer_zero_flag;
		logic timer_irq_enable;
		logic converter_done_flag;
		logic converter_irq_enable;
		logic reload_overflow_flag;
		logic reload_overflow_irq_enable;
		logic reload_compare_flag;
		logic reload_compare_irq_enable;
		logic reload_edge_flag;
		logic reload_edge_irq_enable;
		logic serial_running_flag;
		logic serial_irq_enable;
	} periph_type;

	// Core execution mode at the moment of a wait or stop
	typedef enum logic [1:0] {
		mode_normal,
		mode_irq,
		mode_nmi
	} core_mode_type;

endpackage : irq_wake_pkg

// ---- rtl/irq_wake_ctrl.sv ----
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module irq_wake_ctrl (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic nmi_pin_n,
	input wire logic [7:0] port_a_pins,
	input wire logic [7:0] port_b_pins,
	input wire logic [7:0] port_c_pins,
	input wire logic [7:0] port_a_irq_en,
	input wire logic [7:0] port_b_irq_en,
	input wire logic [7:0] port_c_irq_en,
	input wire irq_wake_pkg::periph_type periph,
	input wire logic instr_boundary,
	input wire logic service_start,
	input wire logic [2:0] service_src,
	input wire logic wait_exec,
	input wire logic stop_exec,
	input wire irq_wake_pkg::core_mode_type core_mode,
	input wire logic watchdog_active,
	input wire logic [1:0] osc_source_sel,
	output logic [4:0] irq_request,
	output logic irq_pending,
	output logic [2:0] irq_vector,
	output logic core_halted,
	output logic osc_stopped,
	output logic instr_skipped,
	output logic wake_pulse,
	output logic wake_service_first,
	output logic [1:0] osc_source_out
);

	// ----------------------------------------
	// Option register
	// ----------------------------------------
	irq_wake_pkg::opt_type opt_ff;
	irq_wake_pkg::opt_type nxt_opt;
	irq_wake_pkg::opt_type act_ff;
	logic [7:0] rdata_ff;
	wire opt_hit = reg_addr == irq_wake_pkg::opt_offset;
	wire opt_write = reg_wr && opt_hit;

	// Unused bits are forced to zero so they never steer anything
	assign nxt_opt = '{
		unused_7: 1'b0,
		src1_level_select: reg_wdata[irq_wake_pkg::src1_level_pos],
		src2_polarity_select: reg_wdata[irq_wake_pkg::src2_polarity_pos],
		global_irq_enable: reg_wdata[irq_wake_pkg::global_en_pos],
		unused_3_0: 4'h0
	};

	// Byte write only; there is no read-modify path
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			opt_ff <= irq_wake_pkg::opt_reset;
		end else if (opt_write) begin
			opt_ff <= nxt_opt;
		end
	end

	// Working copy moves only at an instruction boundary so the
	// current instruction never sees a half-applied mode change
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			act_ff <= irq_wake_pkg::opt_reset;
		end else if (instr_boundary) begin
			act_ff <= opt_ff;
		end
	end

	// Every read, mapped or not, answers zero one cycle later
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rdata_ff <= irq_wake_pkg::read_zero;
		end else if (reg_rd) begin
			rdata_ff <= irq_wake_pkg::read_zero;
		end
	end
	assign reg_rdata = rdata_ff;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	localparam int pin_w = 25;
	logic [pin_w-1:0] s1_ff;
	logic [pin_w-1:0] s2_ff;
	logic [pin_w-1:0] s3_ff;
	logic [pin_w-1:0] pin_ff;
	wire [pin_w-1:0] pin_raw = {nmi_pin_n, port_c_pins, port_b_pins, port_a_pins};
	wire [pin_w-1:0] pin_agree = ~(s2_ff ^ s3_ff);

	// A bit only moves once two later stages agree, which
	// drops single-cycle glitches seen near a clock edge
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s1_ff <= '1;
			s2_ff <= '1;
			s3_ff <= '1;
			pin_ff <= '1;
		end else begin
			s1_ff <= pin_raw;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			pin_ff <= (pin_agree & s3_ff) | (~pin_agree & pin_ff);
		end
	end

	wire [7:0] pa = pin_ff[7:0];
	wire [7:0] pb = pin_ff[15:8];
	wire [7:0] pc = pin_ff[23:16];
	wire nmi_n = pin_ff[24];

	// ----------------------------------------
	// Source lines
	// ----------------------------------------
	// Enabled port A or B pin pulled low asserts its line; port C follows the polarity select
	wire src1_line = |(~pa & port_a_irq_en) | |(~pb & port_b_irq_en);
	wire src2_rise = |(pc & port_c_irq_en);
	wire src2_fall = |(~pc & port_c_irq_en);
	wire src2_line = act_ff.src2_polarity_select ? src2_rise : src2_fall;
	wire serial_done = periph.serial_irq_enable && !periph.serial_running_flag;
	wire src3_line = (periph.reload_overflow_flag && periph.reload_overflow_irq_enable)
		|| (periph.reload_compare_flag && periph.reload_compare_irq_enable)
		|| (periph.reload_edge_flag && periph.reload_edge_irq_enable);
	wire src4_line = (periph.timer_zero_flag && periph.timer_irq_enable)
		|| (periph.converter_done_flag && periph.converter_irq_enable);

	logic nmi_prev_ff;
	logic src1_prev_ff;
	logic src2_prev_ff;
	logic ser_prev_ff;
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			nmi_prev_ff <= 1'b0;
			src1_prev_ff <= 1'b0;
			src2_prev_ff <= 1'b0;
			ser_prev_ff <= 1'b0;
		end else begin
			nmi_prev_ff <= !nmi_n;
			src1_prev_ff <= src1_line;
			src2_prev_ff <= src2_line;
			ser_prev_ff <= serial_done;
		end
	end

	// Each edge term compares a line, settled except the serial one, with its own past
	wire nmi_edge = !nmi_n && !nmi_prev_ff;
	wire src1_edge = src1_line && !src1_prev_ff;
	wire src2_edge = src2_line && !src2_prev_ff;
	wire ser_edge = serial_done && !ser_prev_ff;

	// ----------------------------------------
	// Edge latches
	// ----------------------------------------
	logic nmi_lat_ff;
	logic src1_lat_ff;
	logic src2_lat_ff;
	wire clr0 = service_start && service_src == 3'd0;
	wire clr1 = service_start && service_src == 3'd1;
	wire clr2 = service_start && service_src == 3'd2;

	// A new edge in the clearing cycle wins over the clear; a
	// set latch ignores later edges, so only the first is kept
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			nmi_lat_ff <= 1'b0;
			src1_lat_ff <= 1'b0;
			src2_lat_ff <= 1'b0;
		end else begin
			nmi_lat_ff <= nmi_edge || (nmi_lat_ff && !clr0);
			src1_lat_ff <= (src1_edge && !act_ff.src1_level_select)
				|| (src1_lat_ff && !clr1);
			src2_lat_ff <= src2_edge || ser_edge || (src2_lat_ff && !clr2);
		end
	end

	// ----------------------------------------
	// Requests to the core
	// ----------------------------------------
	// Level mode on source 1 bypasses any stored edge without clearing it
	wire src1_req = act_ff.src1_level_select ? src1_line : src1_lat_ff;
	wire [4:0] raw_req = {src4_line, src3_line, src2_lat_ff, src1_req, nmi_lat_ff};
	wire gen = act_ff.global_irq_enable;
	// Maskable requests are dropped while the global enable is low
	assign irq_request = {raw_req[4:1] & {4{gen}}, raw_req[0]};
	assign irq_pending = |irq_request;

	// Lowest number wins; vector numbers match source numbers
	function automatic logic [2:0] first_src(input logic [4:0] req);
		logic [2:0] n;
		n = 3'd0;
		for (int i = 4; i >= 0; i--) begin
			if (req[i]) begin
				n = 3'(i);
			end
		end
		return n;
	endfunction : first_src

	assign irq_vector = first_src(irq_request);

	// Wake needs the global enable even for the non-maskable line
	wire wake_any = gen && |raw_req;
	// Stop hears pins and the source 2 latch, which a serial edge also sets once latched; sources 3 and 4 are ignored
	wire wake_ext = gen && (raw_req[0] || src1_req
		|| (src2_lat_ff && !ser_edge));

	// ----------------------------------------
	// Power state machine
	// ----------------------------------------
	typedef enum logic [1:0] {
		st_run,
		st_wait,
		st_stop,
		st_settle
	} pwr_type;
	pwr_type pwr_ff;
	pwr_type nxt_pwr;
	logic [12:0] cnt_ff;
	logic [12:0] nxt_cnt;
	logic nmi_entry_ff;
	logic skip_ff;
	logic wake_ff;

	wire enter_req = wait_exec || stop_exec;
	wire skip_now = enter_req && irq_pending;
	// Watchdog turns a stop into a wait
	wire go_stop = stop_exec && !watchdog_active && !irq_pending;
	wire go_wait = enter_req && !go_stop && !irq_pending;

	always_comb begin
		nxt_pwr = pwr_ff;
		nxt_cnt = cnt_ff;
		case (pwr_ff)
			st_run: begin
				if (go_stop) begin
					nxt_pwr = st_stop;
				end else if (go_wait) begin
					nxt_pwr = st_wait;
				end
			end
			st_wait: begin
				if (wake_any) begin
					nxt_pwr = st_run;
				end
			end
			st_stop: begin
				if (wake_ext) begin
					nxt_pwr = st_settle;
					nxt_cnt = irq_wake_pkg::settle_cycles - 13'd1;
				end
			end
			st_settle: begin
				if (cnt_ff == 13'd0) begin
					nxt_pwr = st_run;
				end else begin
					nxt_cnt = cnt_ff - 13'd1;
				end
			end
			default: begin
				nxt_pwr = st_run;
			end
		endcase
	end

	// Synchronous reset here also abandons any low-power state
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pwr_ff <= st_run;
			cnt_ff <= 13'd0;
		end else begin
			pwr_ff <= nxt_pwr;
			cnt_ff <= nxt_cnt;
		end
	end

	wire leaving = pwr_ff != st_run && nxt_pwr == st_run;

	// Entry mode decides how the core resumes
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			nmi_entry_ff <= 1'b0;
			skip_ff <= 1'b0;
			wake_ff <= 1'b0;
		end else begin
			if (pwr_ff == st_run && enter_req) begin
				nmi_entry_ff <= core_mode == irq_wake_pkg::mode_nmi;
			end
			skip_ff <= skip_now;
			wake_ff <= leaving;
		end
	end

	assign core_halted = pwr_ff != st_run;
	assign osc_stopped = pwr_ff == st_stop;
	assign instr_skipped = skip_ff;
	assign wake_pulse = wake_ff;
	// From normal or interrupt routine the request is serviced first
	assign wake_service_first = wake_ff && !nmi_entry_ff;
	// Selection passes straight through; waking never touches it
	assign osc_source_out = osc_source_sel;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	sequence stop_woken;
		pwr_ff == st_stop && wake_ext;
	endsequence

	sequence settle_run;
		(pwr_ff == st_settle) [*8];
	endsequence

	a_opt_write_lag: assert property (
		!instr_boundary |=> $stable(act_ff))
		else $error("option applied off boundary");

	a_opt_boundary_apply: assert property (
		instr_boundary |=> act_ff == $past(opt_ff))
		else $error("option not applied at boundary");

	a_unused_bits_zero: assert property (
		opt_ff.unused_7 == 1'b0 && opt_ff.unused_3_0 == 4'h0)
		else $error("unused option bits stored");

	a_read_gives_zero: assert property (
		reg_rd |=> reg_rdata == 8'h00)
		else $error("option register readable");

	a_mask_global: assert property (
		!gen |-> irq_request[4:1] == 4'h0)
		else $error("maskable request with enable low");

	a_nmi_no_wake: assert property (
		pwr_ff == st_wait && !gen |=> pwr_ff == st_wait)
		else $error("woke with enable low");

	a_wait_fast: assert property (
		pwr_ff == st_wait && wake_any |=> pwr_ff == st_run && wake_pulse)
		else $error("wait wake delayed");

	a_stop_settle: assert property (
		stop_woken |=> settle_run)
		else $error("stop wake skipped settling");

	a_stop_only_ext: assert property (
		pwr_ff == st_stop && !wake_ext |=> pwr_ff == st_stop)
		else $error("stop left without pin request");

	a_skip_pending: assert property (
		enter_req && irq_pending && pwr_ff == st_run |=> pwr_ff == st_run && instr_skipped)
		else $error("entered low power with request pending");

	a_edge_hold: assert property (
		src2_lat_ff && !clr2 |=> src2_lat_ff)
		else $error("stored edge lost");

	a_watchdog_stop: assert property (
		watchdog_active |-> pwr_ff != st_stop || $past(pwr_ff) == st_stop)
		else $error("stop with watchdog on");

endmodule : irq_wake_ctrl

// ---- dv/core_model.sv ----
`timescale 1ns/1ps
// Core stand-in that marks instruction boundaries for interrupt sampling
module core_model (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic run_en,
	input wire logic core_halted,
	output logic instr_boundary
);
	logic [1:0] phase_ff;

	// ----------------------------------------
	// Instruction timing
	// ----------------------------------------
	// One boundary per four cycles; no fetch while halted, so no sampling either
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			phase_ff <= 2'h0;
			instr_boundary <= 1'b0;
		end else begin
			phase_ff <= phase_ff + 2'h1;
			instr_boundary <= run_en && !core_halted && phase_ff == 2'h3;
		end
	end
endmodule : core_model

// ---- dv/test_irq_option_and_low_power_wake.sv ----
`timescale 1ns/1ps
module test_irq_option_and_low_power_wake;
	logic ref_clk, reset, reg_wr, reg_rd, nmi_pin_n, instr_boundary, service_start, wait_exec, stop_exec;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, pa, pb, pc, pa_en, pb_en, pc_en, model_opt;
	logic [2:0] service_src, irq_vector;
	logic [4:0] irq_request;
	logic [1:0] osc_sel, osc_out;
	logic irq_pending, core_halted, osc_stopped, instr_skipped, wake_pulse, wake_service_first;
	logic watchdog_active, run_en;
	irq_wake_pkg::periph_type pf, pv;
	irq_wake_pkg::core_mode_type core_mode;
	int bad_count, num_checks;

	irq_wake_ctrl dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .nmi_pin_n(nmi_pin_n),
		.port_a_pins(pa), .port_b_pins(pb), .port_c_pins(pc), .port_a_irq_en(pa_en),
		.port_b_irq_en(pb_en), .port_c_irq_en(pc_en), .periph(pf), .instr_boundary(instr_boundary),
		.service_start(service_start), .service_src(service_src), .wait_exec(wait_exec),
		.stop_exec(stop_exec), .core_mode(core_mode), .watchdog_active(watchdog_active),
		.osc_source_sel(osc_sel), .irq_request(irq_request), .irq_pending(irq_pending),
		.irq_vector(irq_vector), .core_halted(core_halted), .osc_stopped(osc_stopped),
		.instr_skipped(instr_skipped), .wake_pulse(wake_pulse), .wake_service_first(wake_service_first),
		.osc_source_out(osc_out));

	core_model core (.ref_clk(ref_clk), .reset(reset), .run_en(run_en), .core_halted(core_halted),
		.instr_boundary(instr_boundary));

	// 20 MHz clock
	always #25 ref_clk = ~ref_clk;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		tick(0);
		chk("rdata", reg_rdata, 8'h00);
	endtask : rd

	// Model keeps only the bits that mean something
	task automatic setopt(input logic [7:0] d);
		wr(8'hc8, d);
		model_opt = d & 8'h70;
		tick(8);
	endtask : setopt

	task automatic serve(input logic [2:0] s);
		@(posedge ref_clk);
		service_start <= 1'b1;
		service_src <= s;
		@(posedge ref_clk);
		service_start <= 1'b0;
		tick(1);
	endtask : serve

	function automatic logic [7:0] vec(input logic [4:0] q);
		vec = 8'h00;
		for (int i = 4; i >= 0; i--) begin
			if (q[i]) vec = 8'(i);
		end
	endfunction : vec

	task automatic req_is(input logic [4:0] e);
		chk("req", {3'h0, irq_request}, {3'h0, e});
		chk("vector", {5'h0, irq_vector}, vec(e));
		chk("pending", {7'h0, irq_pending}, {7'h0, |e});
	endtask : req_is

	// Level sources three and four from the flags and their enables
	function automatic logic [4:0] lvl_req(input irq_wake_pkg::periph_type p);
		lvl_req = 5'h00;
		lvl_req[4] = model_opt[4] & (p.timer_zero_flag & p.timer_irq_enable
			| p.converter_done_flag & p.converter_irq_enable);
		lvl_req[3] = model_opt[4] & (p.reload_overflow_flag & p.reload_overflow_irq_enable
			| p.reload_compare_flag & p.reload_compare_irq_enable | p.reload_edge_flag & p.reload_edge_irq_enable);
	endfunction : lvl_req

	// Bounded wait; a settle delay would blow the short bound
	task automatic wait_wake(input int lim);
		int n;
		n = 0;
		while (wake_pulse !== 1'b1 && n < lim) begin
			tick(1);
			n++;
		end
		chk("wake", {7'h0, wake_pulse}, 8'h01);
	endtask : wait_wake

	task automatic pulse_wait();
		@(posedge ref_clk);
		wait_exec <= 1'b1;
		@(posedge ref_clk);
		wait_exec <= 1'b0;
		tick(0);
	endtask : pulse_wait

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : final_report

	// Hang guard, well beyond the settle wait
	initial begin
		repeat (8000) @(posedge ref_clk);
		bad_count++;
		final_report();
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		ref_clk = 1'b0;
		reset = 1'b1;
		{reg_wr, reg_rd, service_start, wait_exec, stop_exec, watchdog_active, run_en} = '0;
		{reg_addr, reg_wdata, pa_en, pb_en, pc_en, model_opt, service_src, osc_sel} = '0;
		{pa, pb, pc, nmi_pin_n} = '1;
		pf = '0;
		core_mode = irq_wake_pkg::mode_normal;
		bad_count = 0;
		num_checks = 0;
		void'($urandom(14));
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		run_en <= 1'b1;
		tick(6);
		req_is(5'h00);
		rd(8'hc8);
		rd(8'($urandom));
		wr(8'hc7, 8'h10);
		setopt(8'h8f);
		@(posedge ref_clk);
		pf.timer_zero_flag <= 1'b1;
		pf.timer_irq_enable <= 1'b1;
		tick(2);
		req_is(5'h00);
		@(posedge ref_clk);
		run_en <= 1'b0;
		wr(8'hc8, 8'h10);
		tick(8);
		req_is(5'h00);
		@(posedge ref_clk);
		run_en <= 1'b1;
		model_opt = 8'h10;
		tick(8);
		req_is(5'h10);
		for (int g = 0; g < 2; g++) begin
			setopt(g ? 8'h10 : 8'h00);
			for (int i = 0; i < 12; i++) begin
				@(posedge ref_clk);
				pv = 12'($urandom);
				pv.serial_irq_enable = 1'b0;
				pf <= pv;
				osc_sel <= 2'($urandom);
				tick(2);
				req_is(lvl_req(pv));
				chk("osc_src", {6'h0, osc_out}, {6'h0, osc_sel});
			end
		end
		@(posedge ref_clk);
		pf <= 12'h003;
		tick(2);
		req_is(5'h00);
		@(posedge ref_clk);
		pf.serial_running_flag <= 1'b0;
		tick(2);
		req_is(5'h04);
		@(posedge ref_clk);
		pf.serial_running_flag <= 1'b1;
		tick(2);
		req_is(5'h04);
		serve(3'd2);
		req_is(5'h00);
		setopt(8'h50);
		@(posedge ref_clk);
		pa_en <= 8'h08;
		pa <= 8'hf7;
		tick(10);
		req_is(5'h02);
		@(posedge ref_clk);
		pa <= 8'hff;
		tick(10);
		req_is(5'h00);
		setopt(8'h10);
		@(posedge ref_clk);
		pb_en <= 8'h80;
		pb <= 8'h7f;
		tick(10);
		@(posedge ref_clk);
		pb <= 8'hff;
		tick(10);
		req_is(5'h02);
		serve(3'd1);
		req_is(5'h00);
		for (int p = 0; p < 2; p++) begin
			@(posedge ref_clk);
			pc_en <= 8'h00;
			pc <= p ? 8'h00 : 8'hff;
			setopt(p ? 8'h30 : 8'h10);
			@(posedge ref_clk);
			pc_en <= 8'h01;
			tick(10);
			req_is(5'h00);
			@(posedge ref_clk);
			pc <= p ? 8'h01 : 8'hfe;
			tick(10);
			req_is(5'h04);
			serve(3'd2);
			req_is(5'h00);
		end
		@(posedge ref_clk);
		pc_en <= 8'h00;
		pc <= 8'hff;
		setopt(8'h00);
		@(posedge ref_clk);
		nmi_pin_n <= 1'b0;
		tick(10);
		req_is(5'h01);
		@(posedge ref_clk);
		nmi_pin_n <= 1'b1;
		serve(3'd0);
		req_is(5'h00);
		tick(10);
		pulse_wait();
		chk("halt", {7'h0, core_halted}, 8'h01);
		@(posedge ref_clk);
		nmi_pin_n <= 1'b0;
		tick(10);
		chk("halt", {7'h0, core_halted}, 8'h01);
		@(posedge ref_clk);
		reset <= 1'b1;
		nmi_pin_n <= 1'b1;
		tick(3);
		@(posedge ref_clk);
		reset <= 1'b0;
		model_opt = 8'h00;
		tick(6);
		chk("halt", {7'h0, core_halted}, 8'h00);
		req_is(5'h00);
		setopt(8'h10);
		for (int m = 0; m < 3; m++) begin
			@(posedge ref_clk);
			core_mode <= irq_wake_pkg::core_mode_type'(m);
			pulse_wait();
			chk("halt", {7'h0, core_halted}, 8'h01);
			chk("osc_stop", {7'h0, osc_stopped}, 8'h00);
			@(posedge ref_clk);
			pf <= 12'hc00;
			wait_wake(4);
			chk("first", {7'h0, wake_service_first}, {7'h0, m != 2});
			@(posedge ref_clk);
			pf <= '0;
			tick(2);
		end
		@(posedge ref_clk);
		pf <= 12'hc00;
		pulse_wait();
		chk("skipped", {7'h0, instr_skipped}, 8'h01);
		chk("halt", {7'h0, core_halted}, 8'h00);
		@(posedge ref_clk);
		pf <= '0;
		watchdog_active <= 1'b1;
		stop_exec <= 1'b1;
		@(posedge ref_clk);
		stop_exec <= 1'b0;
		tick(0);
		chk("osc_stop", {7'h0, osc_stopped}, 8'h00);
		chk("halt", {7'h0, core_halted}, 8'h01);
		@(posedge ref_clk);
		pf <= 12'hc00;
		wait_wake(4);
		@(posedge ref_clk);
		pf <= '0;
		watchdog_active <= 1'b0;
		stop_exec <= 1'b1;
		@(posedge ref_clk);
		stop_exec <= 1'b0;
		tick(0);
		chk("osc_stop", {7'h0, osc_stopped}, 8'h01);
		@(posedge ref_clk);
		pf <= 12'hc00;
		tick(10);
		chk("halt", {7'h0, core_halted}, 8'h01);
		@(posedge ref_clk);
		pf <= '0;
		pa <= 8'hf7;
		tick(1900);
		chk("halt", {7'h0, core_halted}, 8'h01);
		wait_wake(400);
		final_report();
	end
endmodule : test_irq_option_and_low_power_wake
